//--- design/auto_power_down_cfg.svh
// constants for the automatic power-down and power-management block
`ifndef AUTO_POWER_DOWN_CFG_SVH
`define AUTO_POWER_DOWN_CFG_SVH
`define APD_IDLE_LIMIT      4'hF
`define PMA_APD_BIT         1
`define PMA_TURBO_OFF_BIT   3
`define PMA_ARRAY_CLK_BIT   4
`define PMA_MCELL_CLK_BIT   5
`define PMA_USED_MASK       8'h3A
`define PMB_CNTL0_BIT       2
`define PMB_CNTL1_BIT       3
`define PMB_CNTL2_BIT       4
`define PMB_STROBE_BIT      5
`define PMB_DBE_BIT         6
`define PMB_USED_MASK       8'h7C
`define PM_RESET_VALUE      8'h00
`endif

//--- design/apd_pkg.sv
// types shared by the power-down block
package apd_pkg;
  typedef enum logic [0:0] {
    PWR_NORMAL = 1'b0,
    PWR_DOWN   = 1'b1
  } pwr_state_type;
  typedef logic [7:0] byte_type;
endpackage

//--- design/idle_counter.sv
// four-bit inactivity counter with power-down state machine
`timescale 1ns/1ps
`include "auto_power_down_cfg.svh"
module idle_counter
  import apd_pkg::*;
(
  input  wire logic clk_sys,       // system clock
  input  wire logic resetn,        // sync reset, active low
  input  wire logic enable,        // auto power-down enable
  input  wire logic clkTick,       // one pulse per clock input rise
  input  wire logic strobeEdge,    // one pulse per strobe edge
  input  wire logic wakeLevel,     // chip select low or reset high
  output logic [3:0] idleCount,    // current idle count
  output logic       powerDown     // power-down flag
);
  logic [3:0]    count_r;          // idle periods seen
  logic [3:0]    count_nxt;
  pwr_state_type state_r;          // normal or down
  pwr_state_type state_nxt;
  wire           reachLimit = (count_r == `APD_IDLE_LIMIT);

  // counter: cleared by strobe edge, counts clock-input ticks
  always_comb begin
    count_nxt = count_r;
    if (!enable || strobeEdge) begin
      count_nxt = 4'h0;
    end else if (clkTick && !reachLimit) begin
      count_nxt = count_r + 4'h1;
    end
  end

  // state: enter at limit, leave on activity or wake level
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PWR_NORMAL: begin
        // entry needs no enable beyond the unit itself
        if (enable && reachLimit && !strobeEdge && !wakeLevel) begin
          state_nxt = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (!enable || strobeEdge || wakeLevel) begin
          state_nxt = PWR_NORMAL;
        end
      end
      default: state_nxt = PWR_NORMAL;
    endcase
  end

  // registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_r <= 4'h0;
      state_r <= PWR_NORMAL;
    end else begin
      count_r <= count_nxt;
      state_r <= state_nxt;
    end
  end

  assign idleCount = count_r;
  assign powerDown = (state_r == PWR_DOWN);

  a_limit_enter: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == PWR_NORMAL && enable && reachLimit && !strobeEdge && !wakeLevel)
      |=> powerDown) else $error("no power-down at idle limit");
  a_edge_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobeEdge |=> (count_r == 4'h0)) else $error("strobe edge did not clear count");
  a_wake_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
    (powerDown && wakeLevel) |=> !powerDown) else $error("wake level ignored");
  a_strobe_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
    (powerDown && strobeEdge) |=> !powerDown) else $error("strobe did not wake");
  a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    // sampled reset keeps the release edge itself out of the check
    (resetn && enable && !strobeEdge && clkTick && !reachLimit)
      |=> (count_r == $past(count_r) + 4'h1))
    else $error("idle count did not step");
  a_no_early: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(powerDown) |-> ($past(count_r) == `APD_IDLE_LIMIT)) else $error("early power-down");
  c_enter_down: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(powerDown));
  c_leave_down: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(powerDown));
endmodule

//--- design/power_mode_regs.sv
// two power-mode registers, cleared only at power-up
`timescale 1ns/1ps
`include "auto_power_down_cfg.svh"
module power_mode_regs
  import apd_pkg::*;
(
  input  wire logic     clk_sys,      // system clock
  input  wire logic     powerUpn,     // power-up clear, active low
  input  wire logic     writeA,       // write strobe register a
  input  wire logic     writeB,       // write strobe register b
  input  wire byte_type writeData,    // write data
  output byte_type      regA,         // power_mode_reg_a
  output byte_type      regB          // power_mode_reg_b
);
  byte_type regA_r;                   // unused bits held zero
  byte_type regB_r;

  // only power-up clears, device reset leaves them
  always_ff @(posedge clk_sys) begin
    if (!powerUpn) begin
      regA_r <= `PM_RESET_VALUE;
      regB_r <= `PM_RESET_VALUE;
    end else begin
      if (writeA) begin
        regA_r <= writeData & `PMA_USED_MASK;
      end
      if (writeB) begin
        regB_r <= writeData & `PMB_USED_MASK;
      end
    end
  end

  assign regA = regA_r;
  assign regB = regB_r;

  a_write_takes: assert property (@(posedge clk_sys) disable iff (!powerUpn)
    writeA |=> (regA_r == ($past(writeData) & `PMA_USED_MASK))) else $error("write lost");
  a_hold_nowrite: assert property (@(posedge clk_sys) disable iff (!powerUpn)
    !writeB |=> $stable(regB_r)) else $error("register b changed unwritten");
endmodule

//--- design/auto_power_down_control.sv
// top of the automatic power-down and power-management block
`timescale 1ns/1ps
`include "auto_power_down_cfg.svh"
module auto_power_down_control
  import apd_pkg::*;
(
  input  wire logic       clk_sys,            // system clock
  input  wire logic       resetn,             // sync reset, active low
  input  wire logic       powerUpn,           // power-up clear, active low
  input  wire logic       deviceReset,        // device reset input, high wakes
  input  wire logic       address_strobe,     // host address strobe pin
  input  wire logic       logic_clock_input,  // dedicated clock input pin
  input  wire logic       chipSelectn,        // chip select input, active low
  input  wire logic       modeWriteA,         // write power_mode_reg_a
  input  wire logic       modeWriteB,         // write power_mode_reg_b
  input  wire byte_type   modeWriteData,      // register write data
  input  wire logic [15:0] hostAddr,          // host address bus
  input  wire byte_type   hostData,           // host data bus
  input  wire logic [2:0] hostCntl,           // host control signals
  input  wire logic       hostDbe,            // host data byte enable
  input  wire logic [2:0] memSelectRaw,       // decoded flash, sram, io selects
  input  wire logic [2:0] csTerm,             // chip-select product terms
  input  wire logic [2:0] csActiveHigh,       // chip-select polarity
  input  wire logic [2:0] csOeTerm,           // output-enable product terms
  input  wire logic [2:0] csDirection,        // direction register bits
  input  wire byte_type   portDataOut,        // data-port drive value
  input  wire logic       portDataOe,         // data-port drive enable
  input  wire byte_type   periphOut,          // peripheral-io drive value
  input  wire logic       periphOe,           // peripheral-io drive enable
  input  wire byte_type   addrOutValue,       // address-out drive value
  output byte_type        power_mode_reg_a,   // register a readback
  output byte_type        power_mode_reg_b,   // register b readback
  output logic            power_down_flag,    // power-down active
  output logic [3:0]      idleCount,          // inactivity count
  output logic            logicTurboOn,       // logic at full speed
  output logic            mcellClkEnable,     // clock tick to macrocells
  output logic            arrayClkEnable,     // clock tick to and array
  output logic [15:0]     memAddr,            // address seen by memories
  output byte_type        memData,            // data seen by memories
  output logic [2:0]      memSelect,          // flash, sram, io block selects
  output logic [2:0]      memStandby,         // memory standby status
  output logic [15:0]     logicAddr,          // address seen by logic
  output byte_type        logicData,          // data seen by logic
  output logic [2:0]      logicCntl,          // control seen by logic
  output logic            logicStrobe,        // strobe seen by logic
  output logic            logicDbe,           // dbe seen by logic
  output logic [2:0]      external_chip_selects, // chip-select pin values
  output logic [2:0]      csPinOe,            // chip-select pin enables
  output byte_type        dataPortOut,        // data-port pin value
  output logic            dataPortOe,         // data-port pin enable
  output byte_type        periphPinOut,       // peripheral pin value
  output logic            periphPinOe,        // peripheral pin enable
  output byte_type        addrPinOut          // address-out pin value
);
  // pin history, inputs are synchronous to clk_sys
  logic       strobe_r;              // last strobe level
  logic       logic_clock_input_r;               // last clock-input level
  logic [15:0] addr_r;               // last address seen
  byte_type   data_r;                // last data seen
  byte_type   dataPort_r;            // data-port pin register
  logic       dataPortOe_r;
  byte_type   periph_r;              // peripheral pin register
  logic       periphOe_r;
  byte_type   addrPin_r;             // address-out pin register
  logic [2:0] csPin_r;               // chip-select pin register
  logic [2:0] csOe_r;

  // register fields
  wire apdEnable  = power_mode_reg_a[`PMA_APD_BIT];
  wire turboOff   = power_mode_reg_a[`PMA_TURBO_OFF_BIT];
  wire arrayClkOff = power_mode_reg_a[`PMA_ARRAY_CLK_BIT];
  wire mcellClkOff = power_mode_reg_a[`PMA_MCELL_CLK_BIT];

  // edge detection on the dedicated pins, plus wake level and bus-change detect
  wire strobeEdge = (address_strobe != strobe_r);
  wire clkTick    = logic_clock_input && !logic_clock_input_r;
  wire wakeLevel  = !chipSelectn || deviceReset;
  wire busMoved   = (hostAddr != addr_r) || (hostData != data_r);

  // power-down gate and memory selection
  wire memBlocked = power_down_flag;
  wire memsOn     = !chipSelectn && !memBlocked;

  // counter sees the raw clock tick, not the gated one
  idle_counter u_idle (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .enable     (apdEnable),
    .clkTick    (clkTick),
    .strobeEdge (strobeEdge),
    .wakeLevel  (wakeLevel),
    .idleCount  (idleCount),
    .powerDown  (power_down_flag)
  );

  power_mode_regs u_regs (
    .clk_sys   (clk_sys),
    .powerUpn  (powerUpn),
    .writeA    (modeWriteA),
    .writeB    (modeWriteB),
    .writeData (modeWriteData),
    .regA      (power_mode_reg_a),
    .regB      (power_mode_reg_b)
  );

  // clock input fans out to macrocells and and array
  assign mcellClkEnable = clkTick && !mcellClkOff;
  assign arrayClkEnable = clkTick && !arrayClkOff;
  // turbo on by default since the register clears to zero
  // logic speed is independent of power-down
  assign logicTurboOn = !turboOff;

  // memories get nothing while powered down
  assign memAddr   = memBlocked ? addr_r : hostAddr;
  assign memData   = memBlocked ? data_r : hostData;
  // chip select high disables flash, sram and io block
  assign memSelect = memsOn ? memSelectRaw : 3'h0;
  // standby unless selected and inputs moving
  assign memStandby = ~(memSelect & {3{busMoved}});

  // logic inputs: power-down blocks bus, bits of register b block controls
  assign logicAddr = memBlocked ? addr_r : hostAddr;
  assign logicData = memBlocked ? data_r : hostData;
  assign logicCntl[0] = hostCntl[0] && !power_mode_reg_b[`PMB_CNTL0_BIT];
  assign logicCntl[1] = hostCntl[1] && !power_mode_reg_b[`PMB_CNTL1_BIT];
  assign logicCntl[2] = hostCntl[2] && !power_mode_reg_b[`PMB_CNTL2_BIT];
  assign logicStrobe  = address_strobe && !power_mode_reg_b[`PMB_STROBE_BIT];
  assign logicDbe     = hostDbe && !power_mode_reg_b[`PMB_DBE_BIT];

  // chip-select outputs: one term, chosen polarity, enable by term or dir
  wire [2:0] csValue = ~(csTerm ^ csActiveHigh);
  wire [2:0] csOe    = csOeTerm | csDirection;

  // pin and history registers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strobe_r     <= 1'b0;
      logic_clock_input_r      <= 1'b0;
      addr_r       <= 16'h0000;
      data_r       <= 8'h00;
      dataPort_r   <= 8'h00;
      dataPortOe_r <= 1'b0;
      periph_r     <= 8'h00;
      periphOe_r   <= 1'b0;
      addrPin_r    <= 8'h00;
      csPin_r      <= 3'h0;
      csOe_r       <= 3'h0;
    end else begin
      strobe_r <= address_strobe;
      logic_clock_input_r  <= logic_clock_input;
      // latch the bus only while awake so blocked inputs stay static
      if (!memBlocked) begin
        addr_r <= hostAddr;
        data_r <= hostData;
      end
      dataPort_r   <= portDataOut;
      dataPortOe_r <= portDataOe && !power_down_flag;
      periph_r     <= periphOut;
      periphOe_r   <= periphOe && !power_down_flag;
      // address pins are undefined in power-down, last value simply held
      if (!power_down_flag) begin
        addrPin_r <= addrOutValue;
      end
      csPin_r <= csValue;
      csOe_r  <= csOe;
    end
  end

  assign dataPortOut           = dataPort_r;
  assign dataPortOe            = dataPortOe_r;
  assign periphPinOut          = periph_r;
  assign periphPinOe           = periphOe_r;
  assign addrPinOut            = addrPin_r;
  assign external_chip_selects = csPin_r;
  assign csPinOe               = csOe_r;

  a_mem_blocked: assert property (@(posedge clk_sys) disable iff (!resetn)
    (power_down_flag && $past(power_down_flag)) |-> (memSelect == 3'h0 && $stable(memAddr)
      && $stable(logicAddr))) else $error("memory not blocked");
  a_cs_disable: assert property (@(posedge clk_sys) disable iff (!resetn)
    chipSelectn |-> (memSelect == 3'h0)) else $error("memories on with chip select high");
  a_tristate_pd: assert property (@(posedge clk_sys) disable iff (!resetn)
    power_down_flag |=> (!dataPortOe && !periphPinOe)) else $error("data port driven in power-down");
  a_cs_polarity: assert property (@(posedge clk_sys) disable iff (!resetn)
    resetn |=> (external_chip_selects == (($past(csTerm) & $past(csActiveHigh))
      | (~$past(csTerm) & ~$past(csActiveHigh))))) else $error("chip select polarity wrong");
  a_block_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
    power_mode_reg_b[`PMB_STROBE_BIT] |-> !logicStrobe) else $error("blocked strobe passed");
  a_mcell_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    mcellClkOff |-> !mcellClkEnable) else $error("macrocell clock not gated");
  c_cs_off: cover property (@(posedge clk_sys) disable iff (!resetn) chipSelectn && power_down_flag);
  c_turbo_off: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(turboOff));
endmodule

//--- test/host_bus_model.sv
// host bus model: strobe activity while awake, foreign bus noise while asleep
`timescale 1ns/1ps
module host_bus_model
  import apd_pkg::*;
(
  input  wire logic  clk_sys,         // system clock
  input  wire logic  busActive,       // host is running bus cycles
  output logic       address_strobe,  // strobe pin drive
  output logic [15:0] hostAddr,       // address lines
  output byte_type   hostData         // data lines
);
  // known levels at time zero
  initial begin
    address_strobe = 1'b0;
    hostAddr       = 16'h0000;
    hostData       = 8'h00;
  end
  // awake host strobes every cycle; asleep host leaves the strobe still
  // while other bus traffic keeps the lines moving
  always @(posedge clk_sys) begin
    if (busActive) begin
      address_strobe <= ~address_strobe;
      hostAddr       <= hostAddr + 16'h0001;
    end else begin
      hostAddr       <= ~hostAddr;
    end
    hostData <= ~hostData;
  end
endmodule

//--- test/testbench.sv
// self-checking bench for the power-down block
`timescale 1ns/1ps
module testbench
  import apd_pkg::*;
();
  logic clk_sys = 1'b0, resetn = 1'b0, powerUpn = 1'b0, deviceReset = 1'b0;
  logic busActive = 1'b1, chipSelectn = 1'b1, modeWriteA = 1'b0, modeWriteB = 1'b0;
  logic portDataOe = 1'b1, periphOe = 1'b1, hostDbe = 1'b1, logic_clock_input = 1'b0;
  logic [1:0] divCnt = 2'b00;         // clock input divider
  byte_type modeWriteData = 8'h00, portDataOut = 8'hA5, periphOut = 8'h3C;
  byte_type addrOutValue = 8'h11;
  logic [2:0] hostCntl = 3'h7, memSelectRaw = 3'h7, csTerm = 3'h5, csActiveHigh = 3'h0;
  logic [2:0] csOeTerm = 3'h1, csDirection = 3'h4;
  logic address_strobe, power_down_flag, logicTurboOn, mcellClkEnable, arrayClkEnable;
  logic logicStrobe, logicDbe, dataPortOe, periphPinOe;
  logic [15:0] hostAddr, memAddr, logicAddr, savedAddr;
  byte_type hostData, power_mode_reg_a, power_mode_reg_b, memData, logicData;
  byte_type dataPortOut, periphPinOut, addrPinOut, savedPin, savedData;
  logic [3:0] idleCount;
  logic [2:0] memSelect, memStandby, logicCntl, external_chip_selects, csPinOe;
  int n_fail = 0, total_checks = 0, nM, nA, hits;

  // 200 MHz system clock
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // clock input pin at a quarter of the system rate
  always @(posedge clk_sys) begin
    divCnt            <= divCnt + 2'b01;
    logic_clock_input <= divCnt[1];
  end

  host_bus_model HOST (.clk_sys(clk_sys), .busActive(busActive),
    .address_strobe(address_strobe), .hostAddr(hostAddr), .hostData(hostData));

  auto_power_down_control DUT (.clk_sys(clk_sys), .resetn(resetn), .powerUpn(powerUpn),
    .deviceReset(deviceReset), .address_strobe(address_strobe),
    .logic_clock_input(logic_clock_input), .chipSelectn(chipSelectn),
    .modeWriteA(modeWriteA), .modeWriteB(modeWriteB), .modeWriteData(modeWriteData),
    .hostAddr(hostAddr), .hostData(hostData), .hostCntl(hostCntl), .hostDbe(hostDbe),
    .memSelectRaw(memSelectRaw), .csTerm(csTerm), .csActiveHigh(csActiveHigh),
    .csOeTerm(csOeTerm), .csDirection(csDirection), .portDataOut(portDataOut),
    .portDataOe(portDataOe), .periphOut(periphOut), .periphOe(periphOe),
    .addrOutValue(addrOutValue), .power_mode_reg_a(power_mode_reg_a),
    .power_mode_reg_b(power_mode_reg_b), .power_down_flag(power_down_flag),
    .idleCount(idleCount), .logicTurboOn(logicTurboOn), .mcellClkEnable(mcellClkEnable),
    .arrayClkEnable(arrayClkEnable), .memAddr(memAddr), .memData(memData),
    .memSelect(memSelect), .memStandby(memStandby), .logicAddr(logicAddr),
    .logicData(logicData), .logicCntl(logicCntl), .logicStrobe(logicStrobe),
    .logicDbe(logicDbe), .external_chip_selects(external_chip_selects),
    .csPinOe(csPinOe), .dataPortOut(dataPortOut), .dataPortOe(dataPortOe),
    .periphPinOut(periphPinOut), .periphPinOe(periphPinOe), .addrPinOut(addrPinOut));

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // value compare, four-state
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write pulse into register a or b
  task automatic writeMode(input logic selB, input byte_type data);
    @(posedge clk_sys);
    modeWriteA    <= ~selB;
    modeWriteB    <= selB;
    modeWriteData <= data;
    @(posedge clk_sys);
    modeWriteA <= 1'b0;
    modeWriteB <= 1'b0;
    @(negedge clk_sys);
  endtask
  // bounded wait for the flag to reach a level
  task automatic waitFlag(input logic exp, input int bound);
    int i;
    total_checks++;
    for (i = 0; i < bound; i++) begin
      @(negedge clk_sys);
      if (power_down_flag === exp) break;
    end
    if (i == bound) begin
      n_fail++;
      $display("FAIL t=%0t flag=%h exp=%h", $time, power_down_flag, exp);
      summarize();
    end
  endtask
  // single strobe level change from the host
  task automatic pulseStrobe;
    @(posedge clk_sys);
    busActive <= 1'b1;
    @(posedge clk_sys);
    busActive <= 1'b0;
    @(negedge clk_sys);
  endtask
  // count clock ticks handed to macrocells and and array
  task automatic countClk;
    nM = 0;
    nA = 0;
    repeat (16) begin
      @(negedge clk_sys);
      nM += (mcellClkEnable === 1'b1);
      nA += (arrayClkEnable === 1'b1);
    end
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn   <= 1'b1;
    powerUpn <= 1'b1;
    @(negedge clk_sys);
    check(power_mode_reg_a, 16'h0000);
    check(power_mode_reg_b, 16'h0000);
    check(logicTurboOn, 16'h0001);
    $display("test power-up done");
    writeMode(1'b0, 8'hFF);
    writeMode(1'b1, 8'hFF);
    check(power_mode_reg_a, 16'h003A);
    check(power_mode_reg_b, 16'h007C);
    check(logicTurboOn, 16'h0000);
    check({logicCntl, logicStrobe, logicDbe}, 16'h0000);
    countClk();
    check(nM + nA, 16'h0000);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check(power_mode_reg_a, 16'h003A);
    writeMode(1'b1, 8'h00);
    check({logicCntl, logicDbe}, 16'h000F);
    $display("test mode registers done");
    check(memSelect, 16'h0000);
    check(logicAddr, hostAddr);
    check(dataPortOe, 16'h0001);
    check({dataPortOut, periphPinOut}, 16'hA53C);
    busActive <= 1'b0;
    waitFlag(1'b1, 200);
    check(idleCount, 16'h000F);
    check(memSelect, 16'h0000);
    savedAddr = memAddr;
    savedData = memData;
    savedPin  = addrPinOut;
    @(posedge clk_sys);
    addrOutValue <= 8'hC3;
    repeat (3) @(negedge clk_sys);
    check(memAddr, savedAddr);
    check(memData, savedData);
    check(logicAddr, savedAddr);
    check(logicData, savedData);
    check(addrPinOut, savedPin);
    check({dataPortOe, periphPinOe}, 16'h0000);
    check(memStandby, 16'h0007);
    check(logicTurboOn, 16'h0000);
    writeMode(1'b0, 8'h02);
    check(logicTurboOn, 16'h0001);
    countClk();
    check(nM > 0 && nA > 0, 16'h0001);
    check(power_down_flag, 16'h0001);
    $display("test power-down entry done");
    for (int k = 0; k < 3; k++) begin
      waitFlag(1'b1, 200);
      if (k == 0) begin
        pulseStrobe();
      end else begin
        // wake levels change on the rising edge like every other input
        @(posedge clk_sys);
        if (k == 1) chipSelectn <= 1'b0;
        else deviceReset <= 1'b1;
      end
      waitFlag(1'b0, 3);
      if (k == 0) check(idleCount < 4'h2, 16'h0001);
      if (k == 1) check(memSelect, 16'h0007);
      if (k == 1) begin
        // awake and selected: moving bus wakes the memories
        @(negedge clk_sys);
        check(memStandby, 16'h0000);
      end
      @(posedge clk_sys);
      chipSelectn <= 1'b1;
      deviceReset <= 1'b0;
    end
    $display("test wake causes done");
    repeat (32) @(negedge clk_sys);
    pulseStrobe();
    hits = 0;
    repeat (40) begin
      @(negedge clk_sys);
      hits += (power_down_flag !== 1'b0);
    end
    check(hits, 16'h0000);
    waitFlag(1'b1, 200);
    $display("test idle restart done");
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys);
      csActiveHigh <= (j == 0) ? 3'h0 : (j == 1) ? 3'h7 : 3'h3;
      repeat (2) @(negedge clk_sys);
      check(external_chip_selects,
            {13'h0000, (csTerm & csActiveHigh) | (~csTerm & ~csActiveHigh)});
      check(csPinOe, 16'h0005);
    end
    $display("test chip-select outputs done");
    summarize();
  end
endmodule
